// ==== verilog/gec_map.svh ====
// Register map, field positions, reset values and timing counts of the gesture engine control
`ifndef GEC_MAP_SVH
`define GEC_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define GEC_ADDR_PULSE_CFG 8'ha6
`define GEC_ADDR_PAIR_SEL 8'haa
`define GEC_ADDR_CONTROL 8'hab
`define GEC_ADDR_LEVEL 8'hae
`define GEC_ADDR_Q_UP 8'hfc
`define GEC_ADDR_Q_DOWN 8'hfd
`define GEC_ADDR_Q_LEFT 8'hfe
`define GEC_ADDR_Q_RIGHT 8'hff
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define GEC_PW_MSB 7
`define GEC_PW_LSB 6
`define GEC_PC_MSB 5
`define GEC_PC_LSB 0
`define GEC_PULSE_CFG_RST 8'h40
`define GEC_PAIR_SEL_RST 2'h0
`define GEC_CTL_FLUSH_BIT 2
`define GEC_CTL_IEN_BIT 1
`define GEC_CTL_ACTIVE_BIT 0
// ----------------------------------------
// Timing
// ----------------------------------------
`define GEC_SYS_CLK_MHZ 250
`define GEC_PULSE_BASE_NS 4000
`define GEC_PULSE_BASE_CYC ((`GEC_PULSE_BASE_NS * `GEC_SYS_CLK_MHZ) / 1000)
`define GEC_QUEUE_DEPTH 32
`endif

// ==== verilog/gec_pkg.sv ====
// Types shared by the gesture engine control
package gec_pkg;
	// One dataset: one byte per direction
	typedef struct packed {
		logic [7:0] up;
		logic [7:0] down;
		logic [7:0] left;
		logic [7:0] right;
	} gec_dataset_type;

	// One register access from the host front end
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} gec_req_type;

	typedef enum logic [1:0] {ENG_OFF, ENG_ON, ENG_LEAVING} gec_eng_type;
	typedef enum logic [1:0] {PLS_IDLE, PLS_ON, PLS_OFF} gec_pls_type;
endpackage

// ==== verilog/gec_control.sv ====
// Gesture engine control: dataset queue and control, pulse train and host register port
`timescale 1ns/100ps
`include "gec_map.svh"

// ----------------------------------------
// Synchronous FIFO with flush
// ----------------------------------------
module gec_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	// Clock, reset and flush
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic flush_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	// Fill level
	output logic [$clog2(DEPTH+1)-1:0] count_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wptr_reg;
	logic [AW-1:0] rptr_reg;
	logic [CW-1:0] count_reg;
	logic push;
	logic pop;

	// Handshakes from the fill level
	assign in_ready_o = (count_reg != CW'(DEPTH));
	assign out_valid_o = (count_reg != '0);
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	assign out_data_o = mem_reg[rptr_reg];
	assign count_o = count_reg;

	// Storage
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem_reg[wptr_reg] <= in_data_i;
	end

	// Pointers and count, flush empties
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i || flush_i)
		begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (push)
				wptr_reg <= (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
			if (pop)
				rptr_reg <= (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
			count_reg <= count_reg + CW'(push) - CW'(pop);
		end
	end
endmodule

// Behaviour
// - Width code 0..3 gives emitter on-time 4, 8, 16, 32 us.
// - Pulse count field plus one pulses on the LED drive pin, 1 to 64.
// - Pulse configuration register resets to 0x40.
// - Pair code 0,3 both pairs; 1 up-down only; 2 left-right only.
// - Single pair runs at double rate; disabled pair bytes carry no result.
// - Flush write empties queue, clears irq flag, data flag, overrun, level.
// - Interrupt enable bit unmasks gesture interrupt sources; clear masks them.
// - Engine-active bit reads 1 while gesture machine runs, else 0.
// - Writing 1 enters gesture operation at once, like entry threshold.
// - Writing 0 leaves gesture only after current conversion completes.
// - Level register reports complete datasets waiting, one count each.
// - Read of 0xFF alone lowers level by one; reads of 0xFC..0xFE leave it.
// - Queue holds 32 datasets of four bytes.
// - Dataset arriving on full queue is dropped and overrun set.
// - Read pointer and level advance only on access to 0xFF.
// - Reads with empty queue return zero bytes.
module gec_control #(
	parameter int PULSE_BASE_CYC = `GEC_PULSE_BASE_CYC,
	parameter int QUEUE_DEPTH = `GEC_QUEUE_DEPTH
) (
	// System clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// Host front end, link clock domain
	input wire logic host_clk_i,
	input wire logic host_rstn_i,
	input wire logic host_req_i,
	input wire gec_pkg::gec_req_type host_req_data_i,
	output logic host_ready_o,
	output logic host_done_o,
	output logic [7:0] host_rdata_o,
	// Sequencer and proximity engine
	input wire logic entry_threshold_i,
	input wire logic exit_threshold_i,
	input wire logic cycle_start_i,
	input wire logic conv_done_i,
	// Dataset stream
	input wire logic ds_valid_i,
	input wire gec_pkg::gec_dataset_type ds_data_i,
	output logic ds_ready_o,
	// Engine outputs
	output logic led_drive_pin_o,
	output logic engine_active_o,
	output logic pair_ud_en_o,
	output logic pair_lr_en_o,
	output logic double_rate_o,
	output logic gest_irq_o
);
	localparam int CW = $clog2(QUEUE_DEPTH+1);
	// Link side handshake
	gec_pkg::gec_req_type req_reg;
	logic req_tgl_reg;
	logic busy_reg;
	logic [2:0] ack_sync_reg;
	logic done_reg;
	logic [7:0] host_rdata_reg;
	// System side handshake
	logic [2:0] req_sync_reg;
	logic ack_tgl_reg;
	logic [7:0] rdata_reg;
	logic acc;
	// Registers and state
	logic [7:0] pulse_cfg_reg;
	logic [1:0] pair_sel_reg;
	logic irq_en_reg;
	logic gest_irq_flag_reg;
	logic queue_overrun_reg;
	gec_pkg::gec_eng_type eng_reg;
	gec_pkg::gec_pls_type pls_reg;
	logic [15:0] pls_cnt_reg;
	logic [6:0] pls_left_reg;
	logic [15:0] pls_width;
	// Queue
	logic flush;
	logic wr_one;
	logic wr_zero;
	logic q_in_valid;
	logic q_in_ready;
	logic q_out_valid;
	logic q_pop;
	logic [CW-1:0] q_count;
	gec_pkg::gec_dataset_type q_in;
	gec_pkg::gec_dataset_type q_head;
	logic [7:0] queue_fill_count;

	// ----------------------------------------
	// Link domain: capture request, return answer
	// ----------------------------------------
	assign host_ready_o = ~busy_reg;
	assign host_done_o = done_reg;
	assign host_rdata_o = host_rdata_reg;

	// Request capture and toggle
	always_ff @(posedge host_clk_i)
	begin
		if (!host_rstn_i)
		begin
			req_reg <= '0;
			req_tgl_reg <= 1'b0;
			busy_reg <= 1'b0;
		end
		else if (host_req_i && !busy_reg)
		begin
			req_reg <= host_req_data_i;
			req_tgl_reg <= ~req_tgl_reg;
			busy_reg <= 1'b1;
		end
		else if (ack_sync_reg[2] != ack_sync_reg[1])
			busy_reg <= 1'b0;
	end

	// Acknowledge synchroniser and answer
	always_ff @(posedge host_clk_i)
	begin
		if (!host_rstn_i)
		begin
			ack_sync_reg <= '0;
			done_reg <= 1'b0;
			host_rdata_reg <= '0;
		end
		else
		begin
			ack_sync_reg <= {ack_sync_reg[1:0], ack_tgl_reg};
			done_reg <= ack_sync_reg[2] != ack_sync_reg[1];
			if (ack_sync_reg[2] != ack_sync_reg[1])
				host_rdata_reg <= rdata_reg;
		end
	end

	// ----------------------------------------
	// System domain: register access
	// ----------------------------------------
	assign acc = req_sync_reg[2] != req_sync_reg[1];
	assign wr_one = acc && req_reg.wr && req_reg.addr == `GEC_ADDR_CONTROL;
	assign flush = wr_one && req_reg.wdata[`GEC_CTL_FLUSH_BIT];
	assign wr_zero = wr_one && !req_reg.wdata[`GEC_CTL_ACTIVE_BIT];
	assign q_pop = acc && !req_reg.wr && req_reg.addr == `GEC_ADDR_Q_RIGHT;
	assign queue_fill_count = 8'(q_count);

	// Request synchroniser and acknowledge
	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			req_sync_reg <= '0;
			ack_tgl_reg <= 1'b0;
		end
		else
		begin
			req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
			if (acc)
				ack_tgl_reg <= ~ack_tgl_reg;
		end
	end

	// Writable configuration
	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			pulse_cfg_reg <= `GEC_PULSE_CFG_RST;
			pair_sel_reg <= `GEC_PAIR_SEL_RST;
			irq_en_reg <= 1'b0;
		end
		else if (acc && req_reg.wr)
		begin
			if (req_reg.addr == `GEC_ADDR_PULSE_CFG)
				pulse_cfg_reg <= req_reg.wdata;
			if (req_reg.addr == `GEC_ADDR_PAIR_SEL)
				pair_sel_reg <= req_reg.wdata[1:0];
			if (wr_one)
				irq_en_reg <= req_reg.wdata[`GEC_CTL_IEN_BIT];
		end
	end

	// Read data, empty queue reads zero
	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
			rdata_reg <= '0;
		else if (acc && !req_reg.wr)
		begin
			unique case (req_reg.addr)
				`GEC_ADDR_PULSE_CFG: rdata_reg <= pulse_cfg_reg;
				`GEC_ADDR_PAIR_SEL: rdata_reg <= {6'h00, pair_sel_reg};
				`GEC_ADDR_CONTROL: rdata_reg <= {6'h00, irq_en_reg, engine_active_o};
				`GEC_ADDR_LEVEL: rdata_reg <= queue_fill_count;
				`GEC_ADDR_Q_UP: rdata_reg <= q_out_valid ? q_head.up : 8'h00;
				`GEC_ADDR_Q_DOWN: rdata_reg <= q_out_valid ? q_head.down : 8'h00;
				`GEC_ADDR_Q_LEFT: rdata_reg <= q_out_valid ? q_head.left : 8'h00;
				`GEC_ADDR_Q_RIGHT: rdata_reg <= q_out_valid ? q_head.right : 8'h00;
				default: rdata_reg <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Engine mode
	// ----------------------------------------
	assign engine_active_o = eng_reg != gec_pkg::ENG_OFF;

	// Entry at once, exit after the running conversion
	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
			eng_reg <= gec_pkg::ENG_OFF;
		else if ((wr_one && req_reg.wdata[`GEC_CTL_ACTIVE_BIT]) || entry_threshold_i)
			eng_reg <= gec_pkg::ENG_ON;
		else
		begin
			unique case (eng_reg)
				gec_pkg::ENG_OFF: eng_reg <= gec_pkg::ENG_OFF;
				gec_pkg::ENG_ON:
					if (wr_zero || exit_threshold_i)
						eng_reg <= gec_pkg::ENG_LEAVING;
				gec_pkg::ENG_LEAVING:
					if (conv_done_i)
						eng_reg <= gec_pkg::ENG_OFF;
			endcase
		end
	end

	// ----------------------------------------
	// Emitter pulse train
	// ----------------------------------------
	assign pls_width = 16'(PULSE_BASE_CYC << pulse_cfg_reg[`GEC_PW_MSB:`GEC_PW_LSB]);
	assign led_drive_pin_o = pls_reg == gec_pkg::PLS_ON;

	// On for the width, off for the width, count plus one pulses
	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			pls_reg <= gec_pkg::PLS_IDLE;
			pls_cnt_reg <= '0;
			pls_left_reg <= '0;
		end
		else
		begin
			unique case (pls_reg)
				gec_pkg::PLS_IDLE:
					if (cycle_start_i && engine_active_o)
					begin
						pls_reg <= gec_pkg::PLS_ON;
						pls_cnt_reg <= pls_width - 16'h0001;
						pls_left_reg <= {1'b0, pulse_cfg_reg[`GEC_PC_MSB:`GEC_PC_LSB]};
					end
				gec_pkg::PLS_ON:
					if (pls_cnt_reg == '0)
					begin
						pls_reg <= gec_pkg::PLS_OFF;
						pls_cnt_reg <= pls_width - 16'h0001;
					end
					else
						pls_cnt_reg <= pls_cnt_reg - 16'h0001;
				gec_pkg::PLS_OFF:
					if (pls_cnt_reg != '0)
						pls_cnt_reg <= pls_cnt_reg - 16'h0001;
					else if (pls_left_reg == '0)
						pls_reg <= gec_pkg::PLS_IDLE;
					else
					begin
						pls_reg <= gec_pkg::PLS_ON;
						pls_cnt_reg <= pls_width - 16'h0001;
						pls_left_reg <= pls_left_reg - 7'h01;
					end
			endcase
		end
	end

	// ----------------------------------------
	// Photodiode pairs and dataset queue
	// ----------------------------------------
	assign pair_ud_en_o = pair_sel_reg != 2'h2;
	assign pair_lr_en_o = pair_sel_reg != 2'h1;
	assign double_rate_o = pair_ud_en_o ^ pair_lr_en_o;
	assign q_in.up = pair_ud_en_o ? ds_data_i.up : 8'h00;
	assign q_in.down = pair_ud_en_o ? ds_data_i.down : 8'h00;
	assign q_in.left = pair_lr_en_o ? ds_data_i.left : 8'h00;
	assign q_in.right = pair_lr_en_o ? ds_data_i.right : 8'h00;
	assign q_in_valid = ds_valid_i && engine_active_o && !flush;
	assign ds_ready_o = q_in_ready;
	assign gest_irq_o = gest_irq_flag_reg && irq_en_reg;

	gec_fifo #(
		.WIDTH(32),
		.DEPTH(QUEUE_DEPTH)
	) u_queue (
		.clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.flush_i(flush),
		.in_valid_i(q_in_valid),
		.in_ready_o(q_in_ready),
		.in_data_i(q_in),
		.out_valid_o(q_out_valid),
		.out_ready_i(q_pop),
		.out_data_o(q_head),
		.count_o(q_count)
	);

	// Sticky flags, set wins over clear
	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			gest_irq_flag_reg <= 1'b0;
			queue_overrun_reg <= 1'b0;
		end
		else
		begin
			if (q_in_valid && q_in_ready)
				gest_irq_flag_reg <= 1'b1;
			else if (flush || (q_pop && q_count == CW'(1)))
				gest_irq_flag_reg <= 1'b0;
			if (q_in_valid && !q_in_ready)
				queue_overrun_reg <= 1'b1;
			else if (flush)
				queue_overrun_reg <= 1'b0;
		end
	end
endmodule

// ==== verilog/gec_unused_none.sv ====
// Spare design file: holds no logic, all modules stand in gec_control.sv

// ==== verification/gec_control_checker.sv ====
// Port checker of the gesture engine control
`timescale 1ns/100ps
module gec_control_checker #(
	parameter int PULSE_BASE_CYC = 1000,
	parameter int QUEUE_DEPTH = 32
) (
	// Clocks and resets
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic host_clk_i,
	input wire logic host_rstn_i,
	// Host port
	input wire logic host_req_i,
	input wire logic host_ready_o,
	input wire logic host_done_o,
	// Engine
	input wire logic entry_threshold_i,
	input wire logic conv_done_i,
	input wire logic led_drive_pin_o,
	input wire logic engine_active_o,
	input wire logic pair_ud_en_o,
	input wire logic pair_lr_en_o,
	input wire logic double_rate_o
);
	// ---
	// Emitter run length
	// ---
	int hi_reg;
	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
			hi_reg <= 0;
		else
			hi_reg <= led_drive_pin_o ? hi_reg + 1 : 0;
	end
	// ---
	// Engine properties
	// ---
	property p_pulse_len;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		!led_drive_pin_o && hi_reg != 0 |-> hi_reg inside {PULSE_BASE_CYC,
			2 * PULSE_BASE_CYC, 4 * PULSE_BASE_CYC, 8 * PULSE_BASE_CYC};
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
	property p_pair_some;
		@(posedge sys_clk_i) disable iff (!rstn_i) pair_ud_en_o || pair_lr_en_o;
	endproperty
	a_pair_some: assert property (p_pair_some) else $error("no pair enabled");
	property p_rate;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		double_rate_o == (pair_ud_en_o != pair_lr_en_o);
	endproperty
	a_rate: assert property (p_rate) else $error("double rate wrong");
	property p_enter;
		@(posedge sys_clk_i) disable iff (!rstn_i) entry_threshold_i |=> engine_active_o;
	endproperty
	a_enter: assert property (p_enter) else $error("entry not taken");
	property p_stay;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		engine_active_o && !conv_done_i |=> engine_active_o;
	endproperty
	a_stay: assert property (p_stay) else $error("left before conversion end");
	property p_fall;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		$fell(engine_active_o) |-> $past(conv_done_i);
	endproperty
	a_fall: assert property (p_fall) else $error("exit without conversion end");
	// ---
	// Host port properties
	// ---
	sequence s_taken;
		host_req_i && host_ready_o;
	endsequence
	sequence s_answer;
		##1 !host_ready_o ##[2:7] host_done_o;
	endsequence
	property p_answer;
		@(posedge host_clk_i) disable iff (!host_rstn_i) s_taken |-> s_answer;
	endproperty
	a_answer: assert property (p_answer) else $error("access not answered");
	property p_done_one;
		@(posedge host_clk_i) disable iff (!host_rstn_i) host_done_o |=> !host_done_o;
	endproperty
	a_done_one: assert property (p_done_one) else $error("done too long");
endmodule

bind gec_control gec_control_checker #(.PULSE_BASE_CYC(PULSE_BASE_CYC),
	.QUEUE_DEPTH(QUEUE_DEPTH)) chk_u (.sys_clk_i, .rstn_i, .host_clk_i, .host_rstn_i,
	.host_req_i, .host_ready_o, .host_done_o, .entry_threshold_i, .conv_done_i,
	.led_drive_pin_o, .engine_active_o, .pair_ud_en_o, .pair_lr_en_o, .double_rate_o);

// ==== verification/gec_host_model.sv ====
// Host processor model issuing one register access at a time
`timescale 1ns/100ps
module gec_host_model (
	// Link clock
	input wire logic host_clk_i,
	// Request
	output logic host_req_o,
	output gec_pkg::gec_req_type host_req_data_o,
	// Answer
	input wire logic host_ready_i,
	input wire logic host_done_i,
	input wire logic [7:0] host_rdata_i
);
	int n_late = 0;
	// Idle request
	initial
	begin
		host_req_o = 1'b0;
		host_req_data_o = '0;
	end
	// Hold until taken, then wait for done
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] rd);
		int n;
		n = 0;
		@(posedge host_clk_i);
		host_req_o <= 1'b1;
		host_req_data_o <= {wr, a, d};
		do @(posedge host_clk_i); while (!host_ready_i && ++n < 20);
		host_req_o <= 1'b0;
		host_req_data_o <= ~{wr, a, d}; // No stale value
		do @(posedge host_clk_i); while (!host_done_i && ++n < 20);
		rd = host_rdata_i;
		if (n >= 20) n_late++;
	endtask
endmodule

// ==== verification/test_gesture_engine_control.sv ====
// Bench of the gesture engine control against a queue model
`timescale 1ns/100ps
module test_gesture_engine_control;
	logic sys_clk = 0, host_clk = 0, rstn = 0, hrstn = 0, req, ready, done, ds_ready;
	logic led, act, ud, lr, dr, irq, ds_valid = 0;
	logic [3:0] pls = 4'h0;
	logic [7:0] rdata;
	logic [31:0] ds_data = 32'h0;
	gec_pkg::gec_req_type req_d;
	int n_fail = 0, samples_checked = 0, seed = 86468, psel = 0, pcfg = 8'h40, mien = 0;
	int mact = 0, q[$];
	// Clocks
	initial forever #2 sys_clk = ~sys_clk;
	initial #7 forever #32 host_clk = ~host_clk;
	gec_control #(.PULSE_BASE_CYC(4), .QUEUE_DEPTH(32)) dut_u (.sys_clk_i(sys_clk),
		.rstn_i(rstn), .host_clk_i(host_clk), .host_rstn_i(hrstn), .host_req_i(req),
		.host_req_data_i(req_d), .host_ready_o(ready), .host_done_o(done),
		.host_rdata_o(rdata), .entry_threshold_i(pls[2]), .exit_threshold_i(pls[3]),
		.cycle_start_i(pls[1]), .conv_done_i(pls[0]), .ds_valid_i(ds_valid),
		.ds_data_i(ds_data), .ds_ready_o(ds_ready), .led_drive_pin_o(led),
		.engine_active_o(act), .pair_ud_en_o(ud), .pair_lr_en_o(lr),
		.double_rate_o(dr), .gest_irq_o(irq));
	gec_host_model host_u (.host_clk_i(host_clk), .host_req_o(req), .host_req_data_o(req_d),
		.host_ready_i(ready), .host_done_i(done), .host_rdata_i(rdata));
	// Compare and count
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test();
		if (n_fail == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Write, model follows
	task automatic wr(logic [7:0] a, logic [7:0] d);
		logic [7:0] rd;
		host_u.access(1'b1, a, d, rd);
		if (a == 8'ha6) pcfg = d;
		if (a == 8'haa) psel = d[1:0];
		if (a == 8'hab) mien = d[1];
		if (a == 8'hab) mact = mact | d[0];
		if (a == 8'hab && d[2]) q.delete();
	endtask
	// Read compared with model
	task automatic rdc(logic [7:0] a);
		logic [7:0] rd;
		logic [31:0] e;
		e = 0;
		case (a)
			8'ha6: e = pcfg;
			8'haa: e = psel;
			8'hab: e = mien * 2 + mact;
			8'hae: e = q.size();
			8'hfc, 8'hfd, 8'hfe, 8'hff: if (q.size()) e = (q[0] >> (8 * (255 - a))) & 255;
		endcase
		host_u.access(1'b0, a, 8'h00, rd);
		chk($sformatf("reg_%h", a), rd, e);
		if (a == 8'hff && q.size()) void'(q.pop_front());
	endtask
	// Offer one dataset
	task automatic push();
		logic [31:0] d, m;
		d = $random(seed);
		m = d;
		if (psel == 1) m[15:0] = 16'h0;
		if (psel == 2) m[31:16] = 16'h0;
		@(negedge sys_clk) chk("ds_ready", ds_ready, q.size() < 32);
		@(posedge sys_clk) ds_valid <= 1'b1;
		ds_data <= d;
		@(posedge sys_clk) ds_valid <= 1'b0;
		if (q.size() < 32) q.push_back(m);
	endtask
	task automatic tick(int k);
		@(posedge sys_clk) pls <= 4'h1 << k;
		@(posedge sys_clk) pls <= 4'h0;
	endtask
	// Main sequence
	initial
	begin
		int hi, rises, cnt;
		logic p;
		logic [7:0] regs[5];
		regs = '{8'ha6, 8'haa, 8'hab, 8'hae, 8'ha0};
		repeat (6) @(posedge host_clk);
		@(posedge sys_clk) rstn <= 1'b1;
		hrstn <= 1'b1;
		foreach (regs[i]) rdc(regs[i]);
		wr(8'hab, 8'h03);
		chk("active", act, 1);
		for (int c = 0; c < 4; c++)
		begin
			cnt = $random(seed) & 3;
			wr(8'ha6, 8'(c * 64 + cnt));
			rdc(8'ha6);
			tick(1);
			hi = 0;
			rises = 0;
			p = 0;
			repeat (300)
			begin
				@(posedge sys_clk);
				hi += led;
				rises += led & !p;
				p = led;
			end
			chk("led_high", hi, (cnt + 1) * (4 << c));
			chk("led_pulses", rises, cnt + 1);
		end
		for (int i = 0; i < 4; i++)
		begin
			wr(8'haa, 8'((i + 2) % 4));
			rdc(8'haa);
			chk("pair_ud", ud, psel != 2);
			chk("pair_lr", lr, psel != 1);
			chk("double_rate", dr, psel == 1 || psel == 2);
		end
		repeat (33) push();
		rdc(8'hae);
		chk("irq_on", irq, 1);
		wr(8'hab, 8'h01);
		chk("irq_off", irq, 0);
		while (q.size() > 0)
		begin
			rdc(8'hfc);
			rdc(8'hfd);
			rdc(8'hfe);
			rdc(8'hae);
			rdc(8'hff);
		end
		for (int a = 252; a < 256; a++) rdc(a[7:0]);
		rdc(8'hae);
		wr(8'hab, 8'h03);
		repeat (3) push();
		repeat (2) @(negedge sys_clk);
		chk("irq_set", irq, 1);
		wr(8'hab, 8'h07);
		rdc(8'hae);
		chk("irq_flush", irq, 0);
		rdc(8'hfc);
		wr(8'hab, 8'h00);
		chk("leaving", act, 1);
		rdc(8'hab);
		tick(0);
		mact = 0;
		@(negedge sys_clk) chk("left", act, 0);
		rdc(8'hab);
		tick(2);
		@(negedge sys_clk) chk("entered", act, 1);
		tick(3);
		@(negedge sys_clk) chk("exit_wait", act, 1);
		tick(0);
		@(negedge sys_clk) chk("exit_done", act, 0);
		chk("host_late", host_u.n_late, 0);
		end_of_test();
	end
	// Watchdog
	initial
	begin
		#300000;
		n_fail++;
		end_of_test();
	end
endmodule
